// [verilog/mam_consts.svh]
// address map constants for the memory address map block
`ifndef MAM_CONSTS_SVH
`define MAM_CONSTS_SVH
// rom side
`define MAM_VEC_BASE    14'h0000
`define MAM_VEC_RESET   14'h0000
`define MAM_ZP_BASE     14'h0000
`define MAM_PAT_BASE    14'h0000
// ram regions
`define MAM_CTL0_LO     10'h000
`define MAM_CTL0_HI     10'h003
`define MAM_FLG_LO      10'h020
`define MAM_FLG_HI      10'h023
`define MAM_REG_HI      10'h03f
`define MAM_MREG_BASE   10'h040
`define MAM_SEG_LO      10'h050
`define MAM_SEG_HI      10'h06f
`define MAM_STK_BASE    10'h3c0
`define MAM_STK_LEVELS  5'h10
// special registers held here
`define MAM_DISP_ADDR   10'h02c
`define MAM_TONE_ADDR   10'h02e
`define MAM_TONE_BIT    2'h3
// bit area masks
`define MAM_CTL_RST     32'h00000000
`define MAM_CTL_USED    32'hccbfffff
`define MAM_CTL_NOSET   32'h44305556
`define MAM_CTL_NOCLR   32'h00020000
`define MAM_RSP_IDX     5'h01
// special register access class, one bit per address
`define MAM_SPR_RD      64'hfffffff0fffffff0
`define MAM_SPR_WR      64'hfffffff0fffffff0
// port widths
`define MAM_D_PINS      4'ha
`define MAM_DISC_OFS    6'h20
`endif

// [verilog/mam_pkg.sv]
// types for the memory address map block
package mam_pkg;
  typedef enum logic [2:0] {
    MAM_OP_RD   = 3'h0,
    MAM_OP_WR   = 3'h1,
    MAM_OP_SET  = 3'h2,
    MAM_OP_CLR  = 3'h3,
    MAM_OP_TST  = 3'h4,
    MAM_OP_MREG_LD  = 3'h5,
    MAM_OP_MREG_XCH = 3'h6
  } mam_op_t;
  typedef enum logic [1:0] {
    MAM_ROM_VEC  = 2'h0,
    MAM_ROM_CALL = 2'h1,
    MAM_ROM_PAT  = 2'h2
  } mam_rom_t;
endpackage : mam_pkg

// [verilog/mam_ram_store.sv]
// digit storage array, deliberately without reset
`timescale 1ns/1ps
module mam_ram_store (
  input  wire logic       mclk_in,
  input  wire logic       we_in,
  input  wire logic [9:0] addr_in,
  input  wire logic [3:0] wdata_in,
  output logic      [3:0] rdata_out
);
  logic [3:0] mem [0:1023];

  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[addr_in];
endmodule : mam_ram_store

// [verilog/mam_addr_map.sv]
// memory address map decoder and access rules
// Contract
// - reset or interrupt fetch starts at a vector in 0000..000f
// - short call reaches only rom 0000..003f
// - pattern fetch reads rom data only in 0000..0fff
// - ram 000..03f decodes to registers, not storage
// - storage digits are not cleared by reset
// - 000..003 interrupt bits reachable only by bit set, clear, test
// - special registers are decoded write-only, read-only or read/write; the read and write masks here are equal, so every one is read/write
// - bit set/clear in special area only on display control and tone bit 3
// - 020..023 flags reachable only by bit set, clear, test
// - memory register digits 040..04f reachable as ram and by load/exchange
// - discrete port pins addressed one pin per access
// - nibble ports accessed as whole 4-bit groups
// - display data at 050.. drives segments, 1 is on
// - stack 3c0..3ff, four digits per level, 16 levels max
`timescale 1ns/1ps
`include "mam_consts.svh"
module mam_addr_map (
  input  wire logic                  mclk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  rom_req_in,
  input  wire mam_pkg::mam_rom_t     rom_kind_in,
  input  wire logic [3:0]            rom_vec_in,
  input  wire logic [5:0]            rom_call_in,
  input  wire logic [11:0]           rom_pat_in,
  output logic      [13:0]           rom_addr_out,
  output logic                       rom_valid_out,
  input  wire logic                  ram_req_in,
  input  wire mam_pkg::mam_op_t      ram_op_in,
  input  wire logic [9:0]            ram_addr_in,
  input  wire logic [1:0]            ram_bit_in,
  input  wire logic [3:0]            ram_wdata_in,
  input  wire logic [3:0]            ram_mreg_idx_in,
  output logic      [3:0]            ram_rdata_out,
  output logic                       ram_test_out,
  output logic                       ram_ack_out,
  output logic                       ram_err_out,
  input  wire logic [31:0]           flag_set_in,
  output logic      [31:0]           ctl_bits_out,
  output logic                       per_rd_out,
  output logic                       per_wr_out,
  output logic      [5:0]            per_addr_out,
  output logic      [3:0]            per_wdata_out,
  input  wire logic [3:0]            per_rdata_in,
  output logic      [3:0]            disp_ctl_out,
  output logic      [3:0]            tone_mode_out,
  output logic      [127:0]          seg_out,
  input  wire logic                  stk_push_in,
  input  wire logic                  stk_pop_in,
  output logic      [9:0]            stk_addr_out,
  output logic                       stk_full_out,
  input  wire logic                  port_req_in,
  input  wire logic                  port_wr_in,
  input  wire logic                  port_nib_in,
  input  wire logic [3:0]            port_idx_in,
  input  wire logic [3:0]            port_wdata_in,
  output logic      [3:0]            port_rdata_out,
  output logic                       port_ack_out,
  output logic                       port_err_out,
  input  wire logic [9:0]            disc_pins_in,
  output logic      [9:0]            disc_pins_out,
  output logic      [9:0]            disc_pins_oe_out,
  input  wire logic [31:0]           nib_pins_in,
  output logic      [31:0]           nib_pins_out,
  output logic      [31:0]           nib_pins_oe_out
);
  function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // masks as parameters so single bits can be selected
  localparam logic [31:0] ctl_used_c  = `MAM_CTL_USED;
  localparam logic [31:0] ctl_noset_c = `MAM_CTL_NOSET;
  localparam logic [31:0] ctl_noclr_c = `MAM_CTL_NOCLR;
  localparam logic [63:0] spr_rd_c    = `MAM_SPR_RD;
  localparam logic [63:0] spr_wr_c    = `MAM_SPR_WR;

  // rom fetch address
  logic [13:0] rom_addr_q, rom_addr_d;
  logic        rom_valid_q, rom_valid_d;

  always_comb begin
    rom_addr_d  = rom_addr_q;
    rom_valid_d = rom_req_in;
    if (rom_req_in) begin
      case (rom_kind_in)
        mam_pkg::MAM_ROM_VEC:  rom_addr_d = `MAM_VEC_BASE | {10'h000, rom_vec_in};
        mam_pkg::MAM_ROM_CALL: rom_addr_d = `MAM_ZP_BASE | {8'h00, rom_call_in};
        mam_pkg::MAM_ROM_PAT:  rom_addr_d = `MAM_PAT_BASE | {2'h0, rom_pat_in};
        default:               rom_addr_d = rom_addr_q;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rom_addr_q  <= `MAM_VEC_RESET;
      rom_valid_q <= 1'b1;
    end else begin
      rom_addr_q  <= rom_addr_d;
      rom_valid_q <= rom_valid_d;
    end
  end
  assign rom_addr_out  = rom_addr_q;
  assign rom_valid_out = rom_valid_q;

  // ram side
  logic [31:0]  ctl_q, ctl_d;
  logic [3:0]   disp_q, disp_d, tone_q, tone_d, rd_q, rd_d;
  logic         tst_q, tst_d, ack_q, ack_d, err_q, err_d;
  logic         pwr_q, pwr_d;
  logic [5:0]   paddr_q, paddr_d;
  logic [3:0]   pwd_q, pwd_d;
  logic [127:0] seg_q, seg_d;
  logic [4:0]   sp_q, sp_d;
  logic         mem_we;
  logic [9:0]   mem_addr, seg_off;
  logic [3:0]   mem_wdata, mem_rdata, bmask;
  logic [4:0]   cidx;
  logic         is_ctl, is_spr, bit_op, per_rd;

  mam_ram_store u_store (
    .mclk_in   (mclk_in),
    .we_in     (mem_we),
    .addr_in   (mem_addr),
    .wdata_in  (mem_wdata),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    ctl_d     = ctl_q;
    disp_d    = disp_q;
    tone_d    = tone_q;
    rd_d      = 4'h0;
    tst_d     = 1'b0;
    ack_d     = ram_req_in;
    err_d     = 1'b0;
    pwr_d     = 1'b0;
    paddr_d   = paddr_q;
    pwd_d     = pwd_q;
    seg_d     = seg_q;
    sp_d      = sp_q;
    mem_we    = 1'b0;
    mem_addr  = ram_addr_in;
    mem_wdata = ram_wdata_in;
    per_rd    = 1'b0;
    bmask     = 4'h1 << ram_bit_in;
    cidx      = {ram_addr_in[5], ram_addr_in[1:0], ram_bit_in};
    is_ctl    = in_rng(ram_addr_in, `MAM_CTL0_LO, `MAM_CTL0_HI)
                || in_rng(ram_addr_in, `MAM_FLG_LO, `MAM_FLG_HI);
    is_spr    = !is_ctl && in_rng(ram_addr_in, `MAM_CTL0_LO, `MAM_REG_HI);
    bit_op    = (ram_op_in == mam_pkg::MAM_OP_SET) || (ram_op_in == mam_pkg::MAM_OP_CLR)
                || (ram_op_in == mam_pkg::MAM_OP_TST);
    if (ram_req_in) begin
      if ((ram_op_in == mam_pkg::MAM_OP_MREG_LD)
          || (ram_op_in == mam_pkg::MAM_OP_MREG_XCH)) begin
        mem_addr = `MAM_MREG_BASE | {6'h00, ram_mreg_idx_in};
        rd_d     = mem_rdata;
        mem_we   = (ram_op_in == mam_pkg::MAM_OP_MREG_XCH);
      end else if (is_ctl) begin
        if (!bit_op || !ctl_used_c[cidx]) begin
          err_d = 1'b1;
        end else if (ram_op_in == mam_pkg::MAM_OP_SET) begin
          ctl_d[cidx] = ctl_q[cidx] | !ctl_noset_c[cidx];
        end else if (ram_op_in == mam_pkg::MAM_OP_CLR) begin
          ctl_d[cidx] = ctl_q[cidx] & ctl_noclr_c[cidx];
          // stack pointer reset bit clears only when written low
          if (cidx == `MAM_RSP_IDX) begin
            sp_d = 5'h00;
          end
        end else begin
          tst_d = ctl_q[cidx];
        end
      end else if (is_spr) begin
        if (ram_addr_in == `MAM_DISP_ADDR) begin
          if (ram_op_in == mam_pkg::MAM_OP_WR) disp_d = ram_wdata_in;
          else if (ram_op_in == mam_pkg::MAM_OP_SET) disp_d = disp_q | bmask;
          else if (ram_op_in == mam_pkg::MAM_OP_CLR) disp_d = disp_q & ~bmask;
          else if (ram_op_in == mam_pkg::MAM_OP_TST) tst_d = |(disp_q & bmask);
          else rd_d = disp_q;
        end else if (ram_addr_in == `MAM_TONE_ADDR) begin
          // tone register, only bit 3 takes bit ops
          if (ram_op_in == mam_pkg::MAM_OP_WR) tone_d = ram_wdata_in;
          else if (ram_op_in == mam_pkg::MAM_OP_RD) rd_d = tone_q;
          else if (ram_bit_in != `MAM_TONE_BIT) err_d = 1'b1;
          else if (ram_op_in == mam_pkg::MAM_OP_SET) tone_d = tone_q | bmask;
          else if (ram_op_in == mam_pkg::MAM_OP_CLR) tone_d = tone_q & ~bmask;
          else tst_d = tone_q[`MAM_TONE_BIT];
        end else if (bit_op) begin
          err_d = 1'b1;
        end else if (ram_op_in == mam_pkg::MAM_OP_WR) begin
          if (spr_wr_c[ram_addr_in[5:0]]) begin
            pwr_d   = 1'b1;
            paddr_d = ram_addr_in[5:0];
            pwd_d   = ram_wdata_in;
          end else begin
            err_d = 1'b1;
          end
        end else if (spr_rd_c[ram_addr_in[5:0]]) begin
          per_rd = 1'b1;
          rd_d   = per_rdata_in;
        end else begin
          err_d = 1'b1;
        end
      end else begin
        // plain storage with read-modify-write bit ops
        rd_d  = mem_rdata;
        tst_d = |(mem_rdata & bmask);
        if (ram_op_in == mam_pkg::MAM_OP_WR) begin
          mem_we = 1'b1;
        end else if (ram_op_in == mam_pkg::MAM_OP_SET) begin
          mem_we    = 1'b1;
          mem_wdata = mem_rdata | bmask;
        end else if (ram_op_in == mam_pkg::MAM_OP_CLR) begin
          mem_we    = 1'b1;
          mem_wdata = mem_rdata & ~bmask;
        end
      end
    end
    seg_off = mem_addr - `MAM_SEG_LO;
    if (mem_we && in_rng(mem_addr, `MAM_SEG_LO, `MAM_SEG_HI)) begin
      seg_d[{seg_off[4:0], 2'h0} +: 4] = mem_wdata;
    end
    // stack level tracking, saturates at 16 levels
    if (stk_push_in && !stk_pop_in && (sp_q < `MAM_STK_LEVELS)) begin
      sp_d = sp_q + 5'h01;
    end else if (stk_pop_in && !stk_push_in && (sp_q != 5'h00)) begin
      sp_d = sp_q - 5'h01;
    end
    // hardware flag sets come last so they beat a same-cycle clear
    ctl_d = (ctl_d | flag_set_in) & `MAM_CTL_USED;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_q   <= `MAM_CTL_RST;
      disp_q  <= 4'h0;
      tone_q  <= 4'h0;
      rd_q    <= 4'h0;
      tst_q   <= 1'b0;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      pwr_q   <= 1'b0;
      paddr_q <= 6'h00;
      pwd_q   <= 4'h0;
      seg_q   <= 128'h0;
      sp_q    <= 5'h00;
    end else begin
      ctl_q   <= ctl_d;
      disp_q  <= disp_d;
      tone_q  <= tone_d;
      rd_q    <= rd_d;
      tst_q   <= tst_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      pwr_q   <= pwr_d;
      paddr_q <= paddr_d;
      pwd_q   <= pwd_d;
      seg_q   <= seg_d;
      sp_q    <= sp_d;
    end
  end

  assign ram_rdata_out = rd_q;
  assign ram_test_out  = tst_q;
  assign ram_ack_out   = ack_q;
  assign ram_err_out   = err_q;
  assign ctl_bits_out  = ctl_q;
  assign per_rd_out    = per_rd;
  assign per_wr_out    = pwr_q;
  assign per_addr_out  = paddr_q;
  assign per_wdata_out = pwd_q;
  assign disp_ctl_out  = disp_q;
  assign tone_mode_out = tone_q;
  assign seg_out       = seg_q;
  assign stk_addr_out  = `MAM_STK_BASE | {4'h0, sp_q[3:0], 2'h0};
  assign stk_full_out  = (sp_q == `MAM_STK_LEVELS);

  // port pins, three-stage sync with agreement filter
  logic [41:0] s1_q, s2_q, s3_q, stab_q, stab_d;
  logic [9:0]  dout_q, dout_d, doe_q, doe_d;
  logic [31:0] rout_q, rout_d, roe_q, roe_d;
  logic [3:0]  prd_q, prd_d;
  logic        pack_q, perr_q, perr_d;

  always_comb begin
    stab_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & stab_q;
    dout_d = dout_q;
    doe_d  = doe_q;
    rout_d = rout_q;
    roe_d  = roe_q;
    prd_d  = 4'h0;
    perr_d = 1'b0;
    if (port_req_in) begin
      if (port_nib_in) begin
        if (port_wr_in) begin
          rout_d[{port_idx_in[2:0], 2'h0} +: 4] = port_wdata_in;
          roe_d[{port_idx_in[2:0], 2'h0} +: 4]  = 4'hf;
        end else begin
          prd_d = stab_q[{1'b0, port_idx_in[2:0], 2'h0} +: 4];
        end
      end else if (port_idx_in >= `MAM_D_PINS) begin
        perr_d = 1'b1;
      end else if (port_wr_in) begin
        dout_d[port_idx_in] = port_wdata_in[0];
        doe_d[port_idx_in]  = 1'b1;
      end else begin
        prd_d = {3'h0, stab_q[`MAM_DISC_OFS + {2'h0, port_idx_in}]};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_q   <= 42'h0;
      s2_q   <= 42'h0;
      s3_q   <= 42'h0;
      stab_q <= 42'h0;
      dout_q <= 10'h000;
      doe_q  <= 10'h000;
      rout_q <= 32'h0;
      roe_q  <= 32'h0;
      prd_q  <= 4'h0;
      pack_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      s1_q   <= {disc_pins_in, nib_pins_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= stab_d;
      dout_q <= dout_d;
      doe_q  <= doe_d;
      rout_q <= rout_d;
      roe_q  <= roe_d;
      prd_q  <= prd_d;
      pack_q <= port_req_in;
      perr_q <= perr_d;
    end
  end

  assign port_rdata_out   = prd_q;
  assign port_ack_out     = pack_q;
  assign port_err_out     = perr_q;
  assign disc_pins_out    = dout_q;
  assign disc_pins_oe_out = doe_q;
  assign nib_pins_out     = rout_q;
  assign nib_pins_oe_out  = roe_q;
endmodule : mam_addr_map

// [tb/mam_addr_map_asserts.sv]
// concurrent checks on the address map decoder ports
`timescale 1ns/1ps
module mam_addr_map_chk (
  input wire logic              mclk_in,
  input wire logic              resetn_in,
  input wire logic              rom_req_in,
  input wire mam_pkg::mam_rom_t rom_kind_in,
  input wire logic [3:0]        rom_vec_in,
  input wire logic [5:0]        rom_call_in,
  input wire logic [13:0]       rom_addr_out,
  input wire logic              rom_valid_out,
  input wire logic              ram_req_in,
  input wire mam_pkg::mam_op_t  ram_op_in,
  input wire logic [9:0]        ram_addr_in,
  input wire logic [3:0]        ram_wdata_in,
  input wire logic [3:0]        ram_rdata_out,
  input wire logic              ram_ack_out,
  input wire logic              ram_err_out,
  input wire logic              per_rd_out,
  input wire logic [3:0]        per_rdata_in,
  input wire logic [127:0]      seg_out,
  input wire logic              stk_push_in,
  input wire logic              stk_pop_in,
  input wire logic [9:0]        stk_addr_out,
  input wire logic              stk_full_out,
  input wire logic              port_req_in,
  input wire logic              port_wr_in,
  input wire logic              port_nib_in,
  input wire logic [3:0]        port_idx_in,
  input wire logic [3:0]        port_wdata_in,
  input wire logic [9:0]        disc_pins_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  logic spr_hit;
  assign spr_hit = ram_addr_in inside {[10'h004:10'h01f], [10'h024:10'h03f]};
  a_rom_vec_addr: assert property (
    rom_req_in && rom_kind_in == mam_pkg::MAM_ROM_VEC
    |=> rom_valid_out && rom_addr_out == {10'h000, $past(rom_vec_in)})
    else $error("vector fetch address wrong");
  a_rom_call_addr: assert property (
    rom_req_in && rom_kind_in == mam_pkg::MAM_ROM_CALL
    |=> rom_addr_out == {8'h00, $past(rom_call_in)}) else $error("call address wrong");
  a_ram_ack_next: assert property (
    ram_req_in |=> ram_ack_out || ram_err_out) else $error("ram request unanswered");
  a_ctl_word_refuse: assert property (
    ram_req_in && ram_op_in == mam_pkg::MAM_OP_RD && ram_addr_in <= 10'h003
    |=> ram_err_out) else $error("word read of control bits taken");
  a_flag_word_refuse: assert property (
    ram_req_in && ram_op_in == mam_pkg::MAM_OP_WR && ram_addr_in inside {[10'h020:10'h023]}
    |=> ram_err_out) else $error("word write of flag bits taken");
  a_spr_bit_refuse: assert property (
    ram_req_in && ram_op_in == mam_pkg::MAM_OP_SET && spr_hit
    && ram_addr_in != 10'h02c && ram_addr_in != 10'h02e
    |=> ram_err_out) else $error("bit set on special register taken");
  a_spr_read_path: assert property (
    ram_req_in && ram_op_in == mam_pkg::MAM_OP_RD && spr_hit
    && ram_addr_in != 10'h02c && ram_addr_in != 10'h02e
    |-> per_rd_out ##1 ram_rdata_out == $past(per_rdata_in))
    else $error("special register read path wrong");
  a_seg_follow: assert property (
    ram_req_in && ram_op_in == mam_pkg::MAM_OP_WR && ram_addr_in == 10'h050
    |=> seg_out[3:0] == $past(ram_wdata_in)) else $error("segment data not driven");
  // the level count wraps the address back into the stack window at 16
  a_stk_push_step: assert property (
    stk_push_in && !stk_pop_in && !stk_full_out
    |=> stk_addr_out == (($past(stk_addr_out) + 10'h004) | 10'h3c0))
    else $error("stack step wrong");
  a_pin_write: assert property (
    port_req_in && port_wr_in && !port_nib_in && port_idx_in <= 4'h9
    |=> disc_pins_out[$past(port_idx_in)] == $past(port_wdata_in[0]))
    else $error("discrete pin write wrong");
  cover property (ram_err_out);
  cover property (stk_full_out);
  cover property (rom_req_in && rom_kind_in == mam_pkg::MAM_ROM_PAT);
endmodule : mam_addr_map_chk
bind mam_addr_map mam_addr_map_chk chk_u (.*);

// [tb/mam_per_model.sv]
// peripheral register model behind the special register strobes
`timescale 1ns/1ps
module mam_per_model (
  input  wire logic       mclk_in,
  input  wire logic       per_rd_in,
  input  wire logic [5:0] rd_addr_in,
  input  wire logic       per_wr_in,
  input  wire logic [5:0] per_addr_in,
  input  wire logic [3:0] per_wdata_in,
  output logic      [3:0] per_rdata_out
);
  logic [3:0] regs [64];
  logic [3:0] last_q;
  initial begin
    last_q = 4'h0;
    for (int i = 0; i < 64; i++) regs[i] = 4'(i) ^ 4'h5;
  end
  // registers answer reads
  // released bus shows the inverse, never a stale digit
  assign per_rdata_out = per_rd_in ? regs[rd_addr_in] : ~last_q;
  always @(posedge mclk_in) begin
    if (per_rd_in) last_q <= regs[rd_addr_in];
    if (per_wr_in) regs[per_addr_in] <= per_wdata_in;
  end
endmodule : mam_per_model

// [tb/mcu_memory_address_map_tb.sv]
// self-checking bench for the address map decoder
`timescale 1ns/1ps
module mcu_memory_address_map_tb;
  logic mclk_in, resetn_in, rom_req_in, rom_valid_out, ram_req_in, ram_test_out;
  logic ram_ack_out, ram_err_out, per_rd_out, per_wr_out, stk_push_in, stk_pop_in;
  logic stk_full_out, port_req_in, port_wr_in, port_nib_in, port_ack_out, port_err_out;
  mam_pkg::mam_rom_t rom_kind_in;
  mam_pkg::mam_op_t  ram_op_in;
  logic [1:0]   ram_bit_in;
  logic [3:0]   rom_vec_in, ram_wdata_in, ram_mreg_idx_in, ram_rdata_out, per_wdata_out, v;
  logic [3:0]   per_rdata_in, disp_ctl_out, tone_mode_out, port_idx_in, port_wdata_in;
  logic [3:0]   port_rdata_out;
  logic [5:0]   rom_call_in, per_addr_out;
  logic [9:0]   ram_addr_in, stk_addr_out, disc_pins_in, disc_pins_out, disc_pins_oe_out;
  logic [11:0]  rom_pat_in;
  logic [13:0]  rom_addr_out;
  logic [31:0]  flag_set_in, ctl_bits_out, nib_pins_in, nib_pins_out, nib_pins_oe_out, e;
  logic [127:0] seg_out;
  logic [3:0]   mem [int];
  logic [3:0]   spr [64];
  int           n_fail = 0, checks = 0, cyc = 0;
  // undriven pins float high
  assign disc_pins_in = disc_pins_out | ~disc_pins_oe_out;
  assign nib_pins_in = nib_pins_out | ~nib_pins_oe_out;
  mam_addr_map dut_u (.*);
  mam_per_model per_u (
    .mclk_in      (mclk_in),
    .per_rd_in    (per_rd_out),
    .rd_addr_in   (ram_addr_in[5:0]),
    .per_wr_in    (per_wr_out),
    .per_addr_in  (per_addr_out),
    .per_wdata_in (per_wdata_out),
    .per_rdata_out(per_rdata_in)
  );
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ram(input mam_pkg::mam_op_t op, input logic [9:0] a, input logic [1:0] b,
                     input logic [3:0] d);
    @(posedge mclk_in) #1;
    ram_req_in = 1'b1;
    ram_op_in = op;
    ram_addr_in = a;
    ram_bit_in = b;
    ram_wdata_in = d;
    ram_mreg_idx_in = a[3:0];
    @(posedge mclk_in) #1;
    ram_req_in = 1'b0;
  endtask : ram
  task automatic pio(input logic w, input logic n, input logic [3:0] i, input logic [3:0] d);
    @(posedge mclk_in) #1;
    port_req_in = 1'b1;
    port_wr_in = w;
    port_nib_in = n;
    port_idx_in = i;
    port_wdata_in = d;
    @(posedge mclk_in) #1;
    port_req_in = 1'b0;
  endtask : pio
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    {mclk_in, resetn_in, rom_req_in, ram_req_in, stk_push_in, stk_pop_in} = '0;
    {port_req_in, port_wr_in, port_nib_in, port_idx_in, port_wdata_in} = '0;
    {rom_vec_in, rom_call_in, rom_pat_in, ram_addr_in, ram_bit_in} = '0;
    {ram_wdata_in, ram_mreg_idx_in, flag_set_in} = '0;
    rom_kind_in = mam_pkg::MAM_ROM_VEC;
    ram_op_in = mam_pkg::MAM_OP_RD;
    void'($urandom(32'hb2d4));
    for (int i = 0; i < 64; i++) spr[i] = 4'(i) ^ 4'h5;
    repeat (6) @(posedge mclk_in);
    chk(rom_valid_out, 1'b1);
    chk(stk_addr_out, 10'h3c0);
    #1 resetn_in = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk_in) #1;
      rom_req_in = 1'b1;
      rom_kind_in = mam_pkg::mam_rom_t'(i % 3);
      {rom_vec_in, rom_call_in, rom_pat_in} = 22'($urandom);
      e = (i % 3 == 0) ? rom_vec_in : (i % 3 == 1) ? rom_call_in : rom_pat_in;
      @(posedge mclk_in) #1;
      rom_req_in = 1'b0;
      chk(rom_valid_out, 1'b1);
      chk(rom_addr_out, e);
    end
    for (int i = 0; i < 16; i++) begin
      mem[64 + i] = 4'($urandom);
      ram(mam_pkg::MAM_OP_WR, 10'h040 + 10'(i), 2'h0, mem[64 + i]);
    end
    for (int i = 0; i < 16; i++) begin
      ram(mam_pkg::MAM_OP_MREG_LD, 10'(i), 2'h0, 4'h0);
      chk(ram_rdata_out, mem[64 + i]);
    end
    chk(ram_ack_out, 1'b1);
    ram(mam_pkg::MAM_OP_MREG_XCH, 10'h005, 2'h0, 4'ha);
    chk(ram_rdata_out, mem[69]);
    mem[69] = 4'ha;
    ram(mam_pkg::MAM_OP_RD, 10'h045, 2'h0, 4'h0);
    chk(ram_rdata_out, mem[69]);
    for (int k = 0; k < 32; k += 31) begin
      v = 4'($urandom);
      ram(mam_pkg::MAM_OP_WR, 10'h050 + 10'(k), 2'h0, v);
      chk(seg_out[4 * k +: 4], v);
    end
    ram(mam_pkg::MAM_OP_RD, 10'h002, 2'h0, 4'h0);
    chk(ram_err_out, 1'b1);
    ram(mam_pkg::MAM_OP_WR, 10'h021, 2'h0, 4'hf);
    chk(ram_err_out, 1'b1);
    ram(mam_pkg::MAM_OP_SET, 10'h000, 2'h0, 4'h0);
    chk(ctl_bits_out[0], 1'b1);
    ram(mam_pkg::MAM_OP_TST, 10'h000, 2'h0, 4'h0);
    chk(ram_test_out, 1'b1);
    ram(mam_pkg::MAM_OP_SET, 10'h020, 2'h0, 4'h0);
    chk(ctl_bits_out[16], 1'b1);
    ram(mam_pkg::MAM_OP_CLR, 10'h020, 2'h0, 4'h0);
    ram(mam_pkg::MAM_OP_TST, 10'h020, 2'h0, 4'h0);
    chk(ram_test_out, 1'b0);
    ram(mam_pkg::MAM_OP_SET, 10'h001, 2'h0, 4'h0);
    chk(ctl_bits_out[4], 1'b0);
    flag_set_in = 32'h00000010;
    ram(mam_pkg::MAM_OP_CLR, 10'h001, 2'h0, 4'h0);
    flag_set_in = 32'h00000000;
    chk(ctl_bits_out[4], 1'b1);
    ram(mam_pkg::MAM_OP_CLR, 10'h001, 2'h0, 4'h0);
    chk(ctl_bits_out[4], 1'b0);
    ram(mam_pkg::MAM_OP_SET, 10'h02c, 2'h2, 4'h0);
    chk(disp_ctl_out[2], 1'b1);
    ram(mam_pkg::MAM_OP_RD, 10'h02c, 2'h0, 4'h0);
    chk(ram_rdata_out, 4'h4);
    ram(mam_pkg::MAM_OP_SET, 10'h02e, 2'h3, 4'h0);
    chk(tone_mode_out[3], 1'b1);
    ram(mam_pkg::MAM_OP_CLR, 10'h02e, 2'h3, 4'h0);
    chk(tone_mode_out[3], 1'b0);
    ram(mam_pkg::MAM_OP_SET, 10'h02e, 2'h1, 4'h0);
    chk(ram_err_out, 1'b1);
    ram(mam_pkg::MAM_OP_CLR, 10'h010, 2'h0, 4'h0);
    chk(ram_err_out, 1'b1);
    v = 4'($urandom);
    ram(mam_pkg::MAM_OP_WR, 10'h010, 2'h0, v);
    chk({per_wr_out, per_addr_out, per_wdata_out}, {1'b1, 6'h10, v});
    spr[16] = v;
    ram(mam_pkg::MAM_OP_RD, 10'h010, 2'h0, 4'h0);
    chk(ram_rdata_out, spr[16]);
    ram(mam_pkg::MAM_OP_RD, 10'h030, 2'h0, 4'h0);
    chk(ram_rdata_out, spr[48]);
    for (int i = 0; i < 10; i += 9) begin
      pio(1'b1, 1'b0, 4'(i), 4'h1);
      chk({disc_pins_out[i], disc_pins_oe_out[i]}, 2'h3);
    end
    chk(port_ack_out, 1'b1);
    pio(1'b1, 1'b0, 4'ha, 4'h1);
    chk(port_err_out, 1'b1);
    v = 4'($urandom);
    pio(1'b1, 1'b1, 4'h2, v);
    chk({nib_pins_out[11:8], nib_pins_oe_out[11:8]}, {v, 4'hf});
    repeat (4) @(posedge mclk_in);
    pio(1'b0, 1'b1, 4'h2, 4'h0);
    chk(port_rdata_out, v);
    pio(1'b0, 1'b0, 4'h9, 4'h0);
    chk(port_rdata_out, 4'h1);
    @(posedge mclk_in) #1;
    stk_push_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1 chk(stk_addr_out, 10'h3c8);
    repeat (20) @(posedge mclk_in);
    #1 stk_push_in = 1'b0;
    chk(stk_full_out, 1'b1);
    stk_pop_in = 1'b1;
    @(posedge mclk_in) #1;
    stk_pop_in = 1'b0;
    chk(stk_addr_out, 10'h3fc);
    ram(mam_pkg::MAM_OP_CLR, 10'h000, 2'h1, 4'h0);
    chk(stk_addr_out, 10'h3c0);
    chk(stk_full_out, 1'b0);
    resetn_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    ram(mam_pkg::MAM_OP_RD, 10'h045, 2'h0, 4'h0);
    chk(ram_rdata_out, mem[69]);
    complete_run();
  end
endmodule : mcu_memory_address_map_tb
